// ---- rtl/sirx_params.svh ----
// constants for the two-wire event and receive-map block
// assumes inclusion by bare name from every design file that needs them
`ifndef SIRX_PARAMS_SVH
`define SIRX_PARAMS_SVH

// =====================================================================
// serial mode field codes
`define SIRX_SMF_DISABLED 3'h0
`define SIRX_SMF_SYNC 3'h1

// =====================================================================
// bit counts and word layout
`define SIRX_BYTE_BITS 4'h8
`define SIRX_ACK_SLOT 4'h9
`define SIRX_LAST_SYNC_BIT 4'h7
`define SIRX_RX_WIDTH 9
`define SIRX_ALT_WIDTH 8
`define SIRX_TOP_BIT_POS 8

`endif

// ---- rtl/sirx_pkg.sv ----
// types shared by the two-wire event and receive-map block
// assumes nothing beyond a SystemVerilog compiler
package sirx_pkg;

    // =================================================================
    // operating mode, gray coded along off -> sync -> two-wire
    typedef enum logic [1:0] {
        SIRX_MODE_OFF  = 2'h0,
        SIRX_MODE_SYNC = 2'h1,
        SIRX_MODE_TWI  = 2'h3
    } sirx_mode_type;

endpackage

// ---- rtl/sirx_line_if.sv ----
// synchronised bus line levels and their edge pulses
// assumes one clock domain, that of the block clock
`timescale 1ns/10ps
`default_nettype none

interface sirx_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;

    modport src (
        output scl,
        output sda,
        output scl_rise,
        output scl_fall,
        output sda_rise,
        output sda_fall
    );

    modport dst (
        input scl,
        input sda,
        input scl_rise,
        input scl_fall,
        input sda_rise,
        input sda_fall
    );
endinterface

`default_nettype wire

// ---- rtl/sirx_line_sync.sv ----
// two-flop synchroniser and edge finder for the clock and data lines
// assumes pins are asynchronous to clk and rst_n is already synchronised
`timescale 1ns/10ps
`default_nettype none

module sirx_line_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // synchronised view
    sirx_line_if.src line
);
    // bus idles high, so lines reset high to avoid false edges
    logic [1:0] scl_meta_q;
    logic [1:0] sda_meta_q;
    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta_q <= 2'h3;
            sda_meta_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= {scl_meta_q[0], scl_pin};
            sda_meta_q <= {sda_meta_q[0], sda_pin};
            scl_prev_q <= scl_meta_q[1];
            sda_prev_q <= sda_meta_q[1];
        end
    end

    // each transition shows as exactly one pulse
    assign line.scl = scl_meta_q[1];
    assign line.sda = sda_meta_q[1];
    assign line.scl_rise = scl_meta_q[1] & ~scl_prev_q;
    assign line.scl_fall = ~scl_meta_q[1] & scl_prev_q;
    assign line.sda_rise = sda_meta_q[1] & ~sda_prev_q;
    assign line.sda_fall = ~sda_meta_q[1] & sda_prev_q;
endmodule

`default_nettype wire

// ---- rtl/sirx_buf2.sv ----
// two-entry buffer with valid/ready on both sides
// assumes a single clock and a synchronised active-low reset
`timescale 1ns/10ps
`default_nettype none

module sirx_buf2 #(
    parameter int WIDTH = 17
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    initial begin
        if (WIDTH < 1) begin
            $error("sirx_buf2: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

`default_nettype wire

// ---- rtl/sirx_top.sv ----
// receive side of a multi-mode serial channel: clock-synchronous and
// two-wire receive, bit placement in the receive buffer, and the
// start, stop, acknowledge and receive event pulses.
// assumes bus pins are asynchronous; configuration inputs are static
// while a transfer is in progress.
//
// Notes on behaviour
// - sda falling while scl high raises the start/stop event
// - sda rising while scl high raises the start/stop event
// - one shared event output; bus busy flag tells start from stop
// - sync mode when mode field is 001 and two-wire select is 0
// - sync mode: receive event after bit 8, edge chosen by polarity
// - sync mode: bits 1..8 land in buffer bits 0..7
// - two-wire ack option: bits 1..8 land in buffer bits 7..0
// - ack option: ack or nack event on ninth scl rising edge
// - receive option: receive event on ninth scl falling edge
// - receive option: bits 1..7 in bits 6..0, bit 8 in bit 8
// - receive option with delay: tx-time read gives bits 7..0
// - sda high at ninth rise means nack, low means ack
`timescale 1ns/10ps
`default_nettype none

`include "sirx_params.svh"

module sirx_top #(
    parameter int RX_WIDTH = `SIRX_RX_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,

    // bus pins, input side only
    input wire logic clock_line_pin,
    input wire logic data_line_pin,

    // configuration
    input wire logic [2:0] serial_mode_field,
    input wire logic two_wire_mode_select,
    input wire logic irq_source_option,
    input wire logic clock_delay_select,
    input wire logic clock_polarity_select,
    input wire logic read_at_tx_irq,

    // event pulses
    output logic start_stop_irq,
    output logic rx_irq,
    output logic ack_irq,
    output logic nack_irq,
    output logic rx_overrun,

    // status
    output logic bus_busy_flag,

    // received words
    output logic [RX_WIDTH-1:0] receive_buffer_reg,
    output logic rx_valid,
    input wire logic rx_ready
);
    // =================================================================
    // elaboration checks
    initial begin
        if (RX_WIDTH != `SIRX_RX_WIDTH) begin
            $error("sirx_top: RX_WIDTH must be 9");
        end
    end

    localparam int BUF_WIDTH = `SIRX_RX_WIDTH + `SIRX_ALT_WIDTH;

    // =================================================================
    // reset release
    logic [1:0] rst_sync_q;
    wire rst_sync_n = rst_sync_q[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // =================================================================
    // line sampling
    sirx_line_if line ();

    sirx_line_sync u_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .scl_pin(clock_line_pin),
        .sda_pin(data_line_pin),
        .line(line)
    );

    // =================================================================
    // mode decode
    function automatic sirx_pkg::sirx_mode_type decode_mode(
        input logic [2:0] smf,
        input logic twi_sel
    );
        sirx_pkg::sirx_mode_type m;
        m = sirx_pkg::SIRX_MODE_OFF;
        if (smf == `SIRX_SMF_DISABLED) begin
            m = sirx_pkg::SIRX_MODE_OFF;
        end else if (twi_sel) begin
            m = sirx_pkg::SIRX_MODE_TWI;
        end else if (smf == `SIRX_SMF_SYNC) begin
            m = sirx_pkg::SIRX_MODE_SYNC;
        end
        return m;
    endfunction

    sirx_pkg::sirx_mode_type mode;
    assign mode = decode_mode(serial_mode_field, two_wire_mode_select);

    wire mode_sync = (mode == sirx_pkg::SIRX_MODE_SYNC);
    wire mode_twi = (mode == sirx_pkg::SIRX_MODE_TWI);

    // =================================================================
    // bus conditions
    // a data edge while the clock line is high is a condition, not data
    wire start_det = mode_twi & line.sda_fall & line.scl;
    wire stop_det = mode_twi & line.sda_rise & line.scl;
    wire cond_det = start_det | stop_det;

    // =================================================================
    // bit counting and shifting
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;

    // sync mode samples on the edge picked by polarity
    wire sync_edge = clock_polarity_select ? line.scl_fall : line.scl_rise;
    wire sync_sample = mode_sync & sync_edge;
    wire twi_sample = mode_twi & line.scl_rise & ~cond_det &
                      (bit_cnt_q < `SIRX_BYTE_BITS);

    wire sync_done = sync_sample & (bit_cnt_q == `SIRX_LAST_SYNC_BIT);
    wire ninth_rise = mode_twi & line.scl_rise & ~cond_det &
                      (bit_cnt_q == `SIRX_BYTE_BITS);
    wire ninth_fall = mode_twi & line.scl_fall & ~cond_det &
                      (bit_cnt_q == `SIRX_ACK_SLOT);

    // sync mode is lsb first, two-wire is msb first
    wire [7:0] shift_sync = {line.sda, shift_q[7:1]};
    wire [7:0] shift_twi = {shift_q[6:0], line.sda};

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        unique case (mode)
            sirx_pkg::SIRX_MODE_OFF: begin
                bit_cnt_d = 4'h0;
            end
            sirx_pkg::SIRX_MODE_SYNC: begin
                if (sync_sample) begin
                    shift_d = shift_sync;
                    bit_cnt_d = sync_done ? 4'h0 : bit_cnt_q + 4'h1;
                end
            end
            sirx_pkg::SIRX_MODE_TWI: begin
                if (cond_det) begin
                    bit_cnt_d = 4'h0;
                end else if (twi_sample) begin
                    shift_d = shift_twi;
                    bit_cnt_d = bit_cnt_q + 4'h1;
                end else if (ninth_rise) begin
                    bit_cnt_d = `SIRX_ACK_SLOT;
                end else if (ninth_fall) begin
                    bit_cnt_d = 4'h0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    // =================================================================
    // receive buffer placement
    // entry carries the normal view and the clock-delay tx-time view
    wire [8:0] word_sync = {1'b0, shift_sync};
    wire [8:0] word_ack = {1'b0, shift_q};
    wire [8:0] word_rcv = {shift_q[0], 1'b0, shift_q[7:1]};

    wire push_sync = sync_done;
    wire push_ack = ninth_rise & ~irq_source_option;
    wire push_rcv = ninth_fall & irq_source_option;
    wire push = push_sync | push_ack | push_rcv;

    wire [8:0] word_main = push_sync ? word_sync :
                           push_rcv ? word_rcv : word_ack;
    wire [7:0] word_alt = push_sync ? shift_sync : shift_q;

    wire buf_in_ready;
    wire [BUF_WIDTH-1:0] buf_out;

    sirx_buf2 #(
        .WIDTH(BUF_WIDTH)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_sync_n),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data({word_alt, word_main}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(buf_out)
    );

    // with clock delay the tx-time read sees the byte in plain order
    wire alt_view = mode_twi & irq_source_option & clock_delay_select &
                    read_at_tx_irq;
    assign receive_buffer_reg = alt_view ?
        {1'b0, buf_out[BUF_WIDTH-1:`SIRX_RX_WIDTH]} :
        buf_out[`SIRX_RX_WIDTH-1:0];

    // =================================================================
    // events and bus state
    logic start_stop_q;
    logic rx_irq_q;
    logic ack_q;
    logic nack_q;
    logic overrun_q;
    logic busy_q;

    // bus cannot be stalled, so a full buffer drops the word and says so
    wire overrun_ev = push & ~buf_in_ready;
    wire busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start_stop_q <= 1'b0;
            rx_irq_q <= 1'b0;
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            overrun_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            start_stop_q <= cond_det;
            rx_irq_q <= sync_done | push_rcv;
            ack_q <= push_ack & ~line.sda;
            nack_q <= push_ack & line.sda;
            overrun_q <= overrun_ev;
            busy_q <= busy_d;
        end
    end

    assign start_stop_irq = start_stop_q;
    assign rx_irq = rx_irq_q;
    assign ack_irq = ack_q;
    assign nack_irq = nack_q;
    assign rx_overrun = overrun_q;
    assign bus_busy_flag = busy_q;
endmodule

`default_nettype wire

// ---- tb/sirx_top_sva.sv ----
// port-level checker for the two-wire event and receive-map block
// assumes it is bound into sirx_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module sirx_top_sva #(
    parameter int RX_WIDTH = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and configuration
    input wire logic clock_line_pin,
    input wire logic data_line_pin,
    input wire logic [2:0] serial_mode_field,
    input wire logic two_wire_mode_select,
    input wire logic irq_source_option,
    input wire logic clock_delay_select,
    input wire logic clock_polarity_select,
    input wire logic read_at_tx_irq,
    // outputs
    input wire logic start_stop_irq,
    input wire logic rx_irq,
    input wire logic ack_irq,
    input wire logic nack_irq,
    input wire logic rx_overrun,
    input wire logic bus_busy_flag,
    input wire logic [RX_WIDTH-1:0] receive_buffer_reg,
    input wire logic rx_valid,
    input wire logic rx_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ===================================================
    // events
    property p_ss_twi;
        start_stop_irq |-> two_wire_mode_select && serial_mode_field != 3'h0;
    endproperty
    a_ss_twi: assert property (p_ss_twi) else $error("condition outside two-wire mode");
    property p_ss_scl;
        start_stop_irq |-> $past(clock_line_pin, 3);
    endproperty
    a_ss_scl: assert property (p_ss_scl) else $error("condition with clock line low");
    property p_busy_src;
        $changed(bus_busy_flag) |-> start_stop_irq || $past(start_stop_irq);
    endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy moved without condition");
    property p_ack_opt;
        (ack_irq || nack_irq) |-> two_wire_mode_select && !irq_source_option && !rx_irq;
    endproperty
    a_ack_opt: assert property (p_ack_opt) else $error("ack event in wrong option");
    property p_ack_low;
        ack_irq |-> !$past(data_line_pin, 3) && !nack_irq;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack with data line high");
    property p_nack_high;
        nack_irq |-> $past(data_line_pin, 3);
    endproperty
    a_nack_high: assert property (p_nack_high) else $error("nack with data line low");
    property p_rx_opt;
        rx_irq |-> (two_wire_mode_select ? irq_source_option : serial_mode_field == 3'h1);
    endproperty
    a_rx_opt: assert property (p_rx_opt) else $error("receive event in wrong mode");
    property p_rx_push;
        rx_irq |-> ##[0:1] rx_valid;
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("receive event without word");
    property p_one_rx;
        rx_irq |=> !rx_irq;
    endproperty
    a_one_rx: assert property (p_one_rx) else $error("receive event too long");
    // a stalled reader must not see the head word move
    property p_hold;
        rx_valid && !rx_ready |=> rx_valid && ($changed(read_at_tx_irq) || $stable(receive_buffer_reg));
    endproperty
    a_hold: assert property (p_hold) else $error("head word lost while stalled");
endmodule

bind sirx_top sirx_top_sva #(.RX_WIDTH(RX_WIDTH)) u_sva (.clk(clk), .rst_n(rst_n),
    .clock_line_pin(clock_line_pin), .data_line_pin(data_line_pin),
    .serial_mode_field(serial_mode_field), .two_wire_mode_select(two_wire_mode_select),
    .irq_source_option(irq_source_option), .clock_delay_select(clock_delay_select),
    .clock_polarity_select(clock_polarity_select), .read_at_tx_irq(read_at_tx_irq),
    .start_stop_irq(start_stop_irq), .rx_irq(rx_irq), .ack_irq(ack_irq),
    .nack_irq(nack_irq), .rx_overrun(rx_overrun), .bus_busy_flag(bus_busy_flag),
    .receive_buffer_reg(receive_buffer_reg), .rx_valid(rx_valid), .rx_ready(rx_ready));

`default_nettype wire

// ---- tb/sirx_bus_model.sv ----
// far-side bus model: a master driving the clock and data lines
// assumes lines idle high by pull-up and the bench calls its tasks
`timescale 1ns/10ps
`default_nettype none

module sirx_bus_model (
    // clock
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // ===================================================
    // line steps, 16 clk per half of a 160 ns clock period
    task automatic put(input logic c, input logic d, input int n);
        scl <= c;
        sda <= d;
        repeat (n) @(posedge clk);
    endtask

    // data moves only with scl low, so no stray condition appears
    task automatic send_bit(input logic b);
        put(1'b0, b, 8);
        put(1'b1, b, 16);
        put(1'b0, b, 8);
    endtask

    task automatic start();
        put(1'b1, 1'b0, 16);
        put(1'b0, 1'b0, 8);
    endtask

    // released data line returns high through the pull-up
    task automatic stop();
        put(1'b0, 1'b0, 8);
        put(1'b1, 1'b0, 8);
        put(1'b1, 1'b1, 16);
    endtask
endmodule

`default_nettype wire

// ---- tb/sirx_top_tb.sv ----
// self-checking bench for the two-wire event and receive-map block
// assumes the bus model on the pins and the bound checker
`timescale 1ns/10ps
`default_nettype none

module sirx_top_tb;
    logic clk;
    logic rst_n;
    logic scl;
    logic sda;
    logic rx_ready;
    logic rdy_stall;
    logic [7:0] cfg;
    logic ss, rx, ak, nk, ov, bus_busy_flag, rx_valid;
    logic [8:0] receive_buffer_reg;
    logic [8:0] wq[$];
    logic [4:0] evq[$];
    int mismatches;
    int checks;
    int seed = 32'h5823;

    // cfg: mode field, two-wire, option, delay, polarity, read view
    sirx_top uut (.clk(clk), .rst_n(rst_n), .clock_line_pin(scl), .data_line_pin(sda),
        .serial_mode_field(cfg[7:5]), .two_wire_mode_select(cfg[4]),
        .irq_source_option(cfg[3]), .clock_delay_select(cfg[2]),
        .clock_polarity_select(cfg[1]), .read_at_tx_irq(cfg[0]),
        .start_stop_irq(ss), .rx_irq(rx), .ack_irq(ak), .nack_irq(nk), .rx_overrun(ov),
        .bus_busy_flag(bus_busy_flag), .receive_buffer_reg(receive_buffer_reg),
        .rx_valid(rx_valid), .rx_ready(rx_ready));
    sirx_bus_model bus (.clk(clk), .scl(scl), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ===================================================
    // compares and verdict
    task automatic chk_word(input string w, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_evt(input logic [4:0] e, input logic [4:0] g);
        chk_word("event", {4'h0, e}, {4'h0, g});
    endtask

    task automatic wrap_up();
        if (wq.size() + evq.size() != 0) begin
            mismatches++;
            $display("wrong value pending expected 0 seen %0d", wq.size() + evq.size());
        end
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ===================================================
    // scoreboard: events and popped words against the notes
    always @(negedge clk) begin
        if (rst_n && {ss, rx, ak, nk, ov} !== 5'h00) begin
            chk_evt((evq.size() != 0) ? evq.pop_front() : 5'h00, {ss, rx, ak, nk, ov});
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (wq.size() == 0) chk_word("word", 9'h000, ~receive_buffer_reg);
            else chk_word("word", wq.pop_front(), receive_buffer_reg);
        end
    end

    always @(posedge clk) rx_ready <= ~rdy_stall & 1'($random(seed));

    // one edge always passes, so back-to-back calls never drive a signal twice in a step
    task automatic drain();
        @(posedge clk);
        for (int t = 0; t < 400 && wq.size() != 0; t++) @(posedge clk);
    endtask

    task automatic frame(input logic [7:0] c, input int n, input logic nak, input int room);
        logic [7:0] d;
        logic [7:0] cf;
        drain();
        // polarity is unused in two-wire mode; the read view only matters with option and delay
        cf = c;
        cf[1] = 1'($random(seed));
        if (!(c[3] && c[2])) cf[0] = 1'($random(seed));
        cfg <= cf;
        rdy_stall <= (room < n);
        evq.push_back(5'h10);
        bus.start();
        chk_word("busy", 9'h001, {8'h00, bus_busy_flag});
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            evq.push_back((c[3] ? 5'h08 : (nak ? 5'h02 : 5'h04)) | 5'(k >= room));
            if (k < room) wq.push_back(cf[3] && !(cf[2] && cf[0]) ? {d[0], 1'b0, d[7:1]} : {1'b0, d});
            for (int i = 7; i >= 0; i--) bus.send_bit(d[i]);
            bus.send_bit(nak);
        end
        evq.push_back(5'h10);
        bus.stop();
        chk_word("busy", 9'h000, {8'h00, bus_busy_flag});
        rdy_stall <= 1'b0;
    endtask

    task automatic sync_byte(input logic [7:0] c);
        logic [7:0] d;
        drain();
        d = 8'($random(seed));
        cfg <= 8'h00;
        bus.put(1'b0, 1'b1, 8);
        cfg <= c;
        if (c[7:5] == 3'h1) evq.push_back(5'h08);
        if (c[7:5] == 3'h1) wq.push_back({1'b0, d});
        for (int i = 0; i < 8; i++) bus.send_bit(d[i]);
        cfg <= 8'h00;
        bus.put(1'b1, 1'b1, 8);
    endtask

    initial begin
        rst_n = 1'b0;
        cfg = 8'h00;
        rdy_stall = 1'b0;
        rx_ready = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        frame(8'h54, 2, 1'b0, 9);
        frame(8'h54, 1, 1'b1, 9);
        frame(8'h5C, 2, 1'b0, 9);
        frame(8'h5D, 1, 1'b0, 9);
        frame(8'h58, 1, 1'b0, 9);
        sync_byte(8'h20);
        sync_byte(8'h22);
        sync_byte(8'h40);
        // a cut byte must leave the bit count clean for the next frame
        cfg <= 8'h54;
        evq.push_back(5'h10);
        bus.start();
        repeat (3) bus.send_bit(1'b0);
        evq.push_back(5'h10);
        bus.stop();
        frame(8'h54, 3, 1'b0, 2);
        drain();
        wrap_up();
    end

    initial begin
        #100000;
        mismatches++;
        $display("wrong value timeout expected 0 seen 1");
        wrap_up();
    end
endmodule

`default_nettype wire
